/* design/exec_pkg.sv */
// Shared constants and types for the skip, argument and bit-operation unit
package exec_pkg;

    // ==========================================================
    // Opcode values
    localparam logic [4:0] OPC_SKP = 5'h18;
    localparam logic [4:0] OPC_ARG = 5'h1E;
    localparam logic [4:0] OPC_BOP = 5'h1F;
    localparam logic [7:0] OPC_MON = 8'hD6;
    localparam logic [1:0] SKP_EXT_ZERO = 2'h0;

    // ==========================================================
    // Instruction field positions
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 11;
    localparam int MON_MSB = 15;
    localparam int MON_LSB = 8;
    localparam int COND_MSB = 10;
    localparam int COND_LSB = 8;
    localparam int EXT_MSB = 7;
    localparam int EXT_LSB = 6;
    localparam int SRC_MSB = 5;
    localparam int SRC_LSB = 3;
    localparam int DST_MSB = 2;
    localparam int DST_LSB = 0;
    localparam int ARG_ADD_POS = 10;
    localparam int ARG_REG_MSB = 9;
    localparam int ARG_REG_LSB = 8;
    localparam int IMM_MSB = 7;
    localparam int IMM_LSB = 0;
    localparam int SUB_MSB = 10;
    localparam int SUB_LSB = 7;
    localparam int BN_MSB = 6;
    localparam int BN_LSB = 3;

    // ==========================================================
    // Register codes; code zero means none, or status for bit ops
    localparam logic [2:0] RC_STS = 3'h0;
    localparam logic [2:0] RC_D = 3'h1;
    localparam logic [2:0] RC_P = 3'h2;
    localparam logic [2:0] RC_B = 3'h3;
    localparam logic [2:0] RC_L = 3'h4;
    localparam logic [2:0] RC_A = 3'h5;
    localparam logic [2:0] RC_T = 3'h6;
    localparam logic [2:0] RC_X = 3'h7;

    // Argument target selector values
    localparam logic [1:0] ARG_SEL_B = 2'h0;
    localparam logic [1:0] ARG_SEL_A = 2'h1;
    localparam logic [1:0] ARG_SEL_T = 2'h2;
    localparam logic [1:0] ARG_SEL_X = 2'h3;

    // ==========================================================
    // Status indicator positions
    localparam int STS_PTM = 0;
    localparam int STS_TG = 1;
    localparam int STS_K = 2;
    localparam int STS_Z = 3;
    localparam int STS_Q = 4;
    localparam int STS_O = 5;
    localparam int STS_C = 6;
    localparam int STS_M = 7;

    // Reset values and trap target
    localparam logic [15:0] GPR_RST = 16'h0000;
    localparam logic [7:0] STS_RST = 8'h00;
    localparam logic [3:0] TRAP_LEVEL = 4'hE;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        cond_equal = 3'b000,
        cond_ge_raw_sign = 3'b001,
        cond_ge_signed = 3'b010,
        cond_ge_unsigned = 3'b011,
        cond_not_equal = 3'b100,
        cond_lt_raw_sign = 3'b101,
        cond_lt_signed = 3'b110,
        cond_lt_unsigned = 3'b111
    } skip_cond_t;

    typedef enum logic [3:0] {
        skip_zero = 4'b0000,
        skip_one = 4'b0001,
        skip_complement = 4'b0010,
        skip_accumulator = 4'b0011,
        write_zero = 4'b0100,
        write_one = 4'b0101,
        write_complement = 4'b0110,
        write_accumulator = 4'b0111,
        store_acc_clear = 4'b1000,
        store_inv_acc_set = 4'b1001,
        load_acc = 4'b1010,
        load_acc_inverted = 4'b1011,
        acc_and_inverted = 4'b1100,
        acc_or_inverted = 4'b1101,
        acc_and_bit = 4'b1110,
        acc_or_bit = 4'b1111
    } bop_sub_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } state_t;

endpackage

/* design/bop_if.sv */
// Carrier between the execution unit and its single-bit operator
`timescale 1ns/1ps
interface bop_if;
    logic [15:0] word;
    logic [3:0] bn;
    logic [3:0] sub;
    logic k_in;
    logic [15:0] word_out;
    logic write;
    logic k_out;
    logic k_write;
    logic skip;

    modport master (output word, bn, sub, k_in,
                    input word_out, write, k_out, k_write, skip);
    modport unit (input word, bn, sub, k_in,
                  output word_out, write, k_out, k_write, skip);
endinterface

/* design/skip_cond_eval.sv */
// Condition evaluation on the difference destination minus source
`timescale 1ns/1ps
module skip_cond_eval
    import exec_pkg::*;
(
    input wire logic [15:0] dst,
    input wire logic [15:0] src,
    input wire logic [2:0] cond,
    output logic skip
);
    logic [16:0] diff;
    logic s_flag;
    logic z_flag;
    logic c_flag;
    logic o_flag;

    // ==========================================================
    // Subtraction flags, carry set when no borrow
    always_comb begin
        diff = {1'b0, dst} + {1'b0, ~src} + 17'h00001;
        s_flag = diff[15];
        z_flag = (diff[15:0] == 16'h0000);
        c_flag = diff[16];
        o_flag = (dst[15] != src[15]) && (diff[15] != dst[15]);
    end

    // Condition select
    always_comb begin
        case (skip_cond_t'(cond))
            cond_equal: skip = z_flag;
            cond_not_equal: skip = !z_flag;
            cond_ge_raw_sign: skip = !s_flag;
            cond_lt_raw_sign: skip = s_flag;
            cond_ge_signed: skip = !(s_flag ^ o_flag);
            cond_lt_signed: skip = s_flag ^ o_flag;
            cond_ge_unsigned: skip = c_flag;
            cond_lt_unsigned: skip = !c_flag;
            default: skip = 1'b0;
        endcase
    end
endmodule

/* design/bit_op_unit.sv */
// Single-bit test, write and accumulator operations
`timescale 1ns/1ps
module bit_op_unit
    import exec_pkg::*;
(
    bop_if.unit b
);
    logic bit_val;

    // ==========================================================
    // Sub-function decode
    always_comb begin
        bit_val = b.word[b.bn];
        b.word_out = b.word;
        b.write = 1'b0;
        b.k_out = b.k_in;
        b.k_write = 1'b0;
        b.skip = 1'b0;
        case (bop_sub_t'(b.sub))
            skip_zero: b.skip = !bit_val;
            skip_one: b.skip = bit_val;
            skip_complement: b.skip = (!bit_val == b.k_in);
            skip_accumulator: b.skip = (bit_val == b.k_in);
            write_zero: begin
                b.word_out[b.bn] = 1'b0;
                b.write = 1'b1;
            end
            write_one: begin
                b.word_out[b.bn] = 1'b1;
                b.write = 1'b1;
            end
            write_complement: begin
                b.word_out[b.bn] = !bit_val;
                b.write = 1'b1;
            end
            write_accumulator: begin
                b.word_out[b.bn] = b.k_in;
                b.write = 1'b1;
            end
            store_acc_clear: begin
                b.word_out[b.bn] = b.k_in;
                b.write = 1'b1;
                b.k_out = 1'b0;
                b.k_write = 1'b1;
            end
            store_inv_acc_set: begin
                b.word_out[b.bn] = !b.k_in;
                b.write = 1'b1;
                b.k_out = 1'b1;
                b.k_write = 1'b1;
            end
            load_acc: begin
                b.k_out = bit_val;
                b.k_write = 1'b1;
            end
            load_acc_inverted: begin
                b.k_out = !bit_val;
                b.k_write = 1'b1;
            end
            acc_and_inverted: begin
                b.k_out = !bit_val && b.k_in;
                b.k_write = 1'b1;
            end
            acc_or_inverted: begin
                b.k_out = !bit_val || b.k_in;
                b.k_write = 1'b1;
            end
            acc_and_bit: begin
                b.k_out = bit_val && b.k_in;
                b.k_write = 1'b1;
            end
            acc_or_bit: begin
                b.k_out = bit_val || b.k_in;
                b.k_write = 1'b1;
            end
            default: b.skip = 1'b0;
        endcase
    end
endmodule

/* design/skip_arg_bitop_exec_unit.sv */
// Execution unit for skips, argument, bit operations and monitor call
`timescale 1ns/1ps
module skip_arg_bitop_exec_unit
    import exec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] instr,
    input wire logic instr_valid,
    output logic instr_ready,
    output logic exec_done,
    output logic exec_skip,
    output logic exec_unhandled,
    input wire logic load_en,
    input wire logic [2:0] load_sel,
    input wire logic [15:0] load_data,
    output logic [15:0] reg_d,
    output logic [15:0] reg_p,
    output logic [15:0] reg_b,
    output logic [15:0] reg_l,
    output logic [15:0] reg_a,
    output logic [15:0] reg_t,
    output logic [15:0] reg_x,
    output logic [7:0] status,
    output logic trap_req,
    output logic [3:0] trap_level,
    output logic [15:0] trap_param
);
    state_t state_reg;
    logic [15:0] instr_reg;
    logic [15:0] gpr_reg [8];
    logic [7:0] sts_reg;
    logic [7:0] sts_next;
    logic trap_req_reg;
    logic [3:0] trap_level_reg;
    logic [15:0] trap_param_reg;
    logic accept;
    logic load_take;
    logic in_exec;
    logic is_skp;
    logic is_arg;
    logic is_bop;
    logic is_mon;
    logic skp_true;
    logic skip_now;
    logic [2:0] src_code;
    logic [2:0] dst_code;
    logic [15:0] src_val;
    logic [15:0] dst_val;
    logic [2:0] arg_code;
    logic arg_add;
    logic [15:0] arg_ext;
    logic [15:0] arg_old;
    logic [16:0] arg_sum17;
    logic arg_carry;
    logic arg_ovf;
    logic [15:0] arg_result;
    logic [15:0] bop_word;
    logic bop_bit_chk;
    logic [15:0] diff_chk;
    bop_if bop ();

    // ==========================================================
    // Register read helpers
    function automatic logic [15:0] read_reg(input logic [2:0] code);
        logic [15:0] v;
        v = 16'h0000;
        if (code != RC_STS) begin
            v = gpr_reg[code];
        end
        return v;
    endfunction

    function automatic logic [2:0] arg_target(input logic [1:0] sel);
        logic [2:0] c;
        c = RC_B;
        case (sel)
            ARG_SEL_B: c = RC_B;
            ARG_SEL_A: c = RC_A;
            ARG_SEL_T: c = RC_T;
            ARG_SEL_X: c = RC_X;
            default: c = RC_B;
        endcase
        return c;
    endfunction

    // ==========================================================
    // Handshake and sequencing
    assign in_exec = (state_reg == ST_EXEC);
    assign instr_ready = (state_reg == ST_IDLE);
    assign accept = instr_valid && instr_ready;
    assign load_take = load_en && instr_ready && !instr_valid;

    // Two-state sequencer: take, then execute
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: state_reg <= ST_IDLE;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Instruction latch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_reg <= 16'h0000;
        end else if (accept) begin
            instr_reg <= instr;
        end
    end

    // ==========================================================
    // Decode
    always_comb begin
        is_skp = (instr_reg[OPC_MSB:OPC_LSB] == OPC_SKP)
            && (instr_reg[EXT_MSB:EXT_LSB] == SKP_EXT_ZERO);
        is_arg = (instr_reg[OPC_MSB:OPC_LSB] == OPC_ARG);
        is_bop = (instr_reg[OPC_MSB:OPC_LSB] == OPC_BOP);
        is_mon = (instr_reg[MON_MSB:MON_LSB] == OPC_MON);
    end

    // Operands; P already points past this instruction
    // Kept in a process so a register write alone re-reads the operands
    always_comb begin
        src_code = instr_reg[SRC_MSB:SRC_LSB];
        dst_code = instr_reg[DST_MSB:DST_LSB];
        src_val = read_reg(src_code);
        dst_val = read_reg(dst_code);
        diff_chk = dst_val - src_val;
    end

    skip_cond_eval u_cond (
        .dst(dst_val),
        .src(src_val),
        .cond(instr_reg[COND_MSB:COND_LSB]),
        .skip(skp_true)
    );

    // ==========================================================
    // Argument group datapath
    always_comb begin
        arg_code = arg_target(instr_reg[ARG_REG_MSB:ARG_REG_LSB]);
        arg_add = instr_reg[ARG_ADD_POS];
        arg_ext = {{8{instr_reg[IMM_MSB]}},
                   instr_reg[IMM_MSB:IMM_LSB]};
        arg_old = read_reg(arg_code);
        arg_sum17 = {1'b0, arg_old} + {1'b0, arg_ext};
        arg_carry = arg_sum17[16];
        arg_ovf = (arg_old[15] == arg_ext[15])
            && (arg_sum17[15] != arg_old[15]);
        arg_result = arg_add ? arg_sum17[15:0] : arg_ext;
    end

    // ==========================================================
    // Bit operator; status word has zeros above bit 7
    assign bop_word = (dst_code == RC_STS) ? {8'h00, sts_reg}
                                           : dst_val;
    assign bop.word = bop_word;
    assign bop.bn = instr_reg[BN_MSB:BN_LSB];
    assign bop.sub = instr_reg[SUB_MSB:SUB_LSB];
    assign bop.k_in = sts_reg[STS_K];
    assign bop_bit_chk = bop_word[bop.bn];

    bit_op_unit u_bop (
        .b(bop)
    );

    // Skip decision for both skip families
    assign skip_now = in_exec
        && ((is_skp && skp_true) || (is_bop && bop.skip));

    // ==========================================================
    // General registers and program counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 8; i++) begin
                gpr_reg[i] <= GPR_RST;
            end
        end else if (accept) begin
            gpr_reg[RC_P] <= gpr_reg[RC_P] + 16'h0001;
        end else if (load_take && load_sel != RC_STS) begin
            gpr_reg[load_sel] <= load_data;
        end else if (in_exec) begin
            if (skip_now) begin
                gpr_reg[RC_P] <= gpr_reg[RC_P] + 16'h0001;
            end
            if (is_arg) begin
                gpr_reg[arg_code] <= arg_result;
            end
            if (is_bop && bop.write && dst_code != RC_STS) begin
                gpr_reg[dst_code] <= bop.word_out;
            end
        end
    end

    // Status register next value; accumulator update lands last
    always_comb begin
        sts_next = sts_reg;
        if (load_take && load_sel == RC_STS) begin
            sts_next = load_data[7:0];
        end else if (in_exec && is_arg && arg_add) begin
            sts_next[STS_C] = arg_carry;
            sts_next[STS_Q] = arg_ovf;
            sts_next[STS_O] = sts_reg[STS_O] || arg_ovf;
        end else if (in_exec && is_bop) begin
            if (bop.write && dst_code == RC_STS) begin
                sts_next = bop.word_out[7:0];
            end
            if (bop.k_write) begin
                sts_next[STS_K] = bop.k_out;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sts_reg <= STS_RST;
        end else begin
            sts_reg <= sts_next;
        end
    end

    // ==========================================================
    // Monitor call trap towards level fourteen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trap_req_reg <= 1'b0;
            trap_level_reg <= 4'h0;
            trap_param_reg <= 16'h0000;
        end else begin
            trap_req_reg <= in_exec && is_mon;
            if (in_exec && is_mon) begin
                trap_level_reg <= TRAP_LEVEL;
                trap_param_reg <= arg_ext;
            end
        end
    end

    // ==========================================================
    // Outputs
    assign exec_done = in_exec;
    assign exec_skip = skip_now;
    assign exec_unhandled = in_exec
        && !(is_skp || is_arg || is_bop || is_mon);
    assign reg_d = gpr_reg[RC_D];
    assign reg_p = gpr_reg[RC_P];
    assign reg_b = gpr_reg[RC_B];
    assign reg_l = gpr_reg[RC_L];
    assign reg_a = gpr_reg[RC_A];
    assign reg_t = gpr_reg[RC_T];
    assign reg_x = gpr_reg[RC_X];
    assign status = sts_reg;
    assign trap_req = trap_req_reg;
    assign trap_level = trap_level_reg;
    assign trap_param = trap_param_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_pc_advance: assert property (
        accept |=> gpr_reg[RC_P] == $past(gpr_reg[RC_P]) + 16'h0001)
        else $error("program counter not advanced on take");

    a_skip_equal: assert property (
        in_exec && is_skp && instr_reg[COND_MSB:COND_LSB] == 3'b000
        |=> gpr_reg[RC_P] == $past(gpr_reg[RC_P])
            + (($past(dst_val) == $past(src_val)) ? 16'h0001 : 16'h0000))
        else $error("equal skip wrong");

    a_skip_rawsign: assert property (
        in_exec && is_skp && instr_reg[COND_MSB:COND_LSB] == 3'b101
        |-> skip_now == diff_chk[15])
        else $error("raw sign skip wrong");

    a_skip_signed: assert property (
        in_exec && is_skp && instr_reg[COND_MSB:COND_LSB] == 3'b010
        |-> skip_now == ($signed(dst_val) >= $signed(src_val)))
        else $error("signed skip wrong");

    a_skip_unsigned: assert property (
        in_exec && is_skp && instr_reg[COND_MSB:COND_LSB] == 3'b111
        |-> skip_now == (dst_val < src_val))
        else $error("unsigned skip wrong");

    a_skip_ext_gap: assert property (
        in_exec && instr_reg[OPC_MSB:OPC_LSB] == OPC_SKP
        && instr_reg[EXT_MSB:EXT_LSB] != 2'b00 |-> !skip_now)
        else $error("extended code decoded as skip");

    a_arg_set: assert property (
        in_exec && is_arg && !arg_add
        |=> gpr_reg[$past(arg_code)] == $past(arg_ext))
        else $error("set argument wrong");

    a_arg_add: assert property (
        in_exec && is_arg && arg_add
        |=> gpr_reg[$past(arg_code)] == $past(arg_old) + $past(arg_ext))
        else $error("add argument wrong");

    a_arg_flags: assert property (
        in_exec && is_arg && arg_add
        |=> sts_reg[STS_C] == $past(arg_carry)
            && sts_reg[STS_Q] == $past(arg_ovf)
            && (!$past(arg_ovf) || sts_reg[STS_O]))
        else $error("add argument flags wrong");

    a_bop_load: assert property (
        in_exec && is_bop && instr_reg[SUB_MSB:SUB_LSB] == 4'b1010
        |=> sts_reg[STS_K] == $past(bop_bit_chk))
        else $error("accumulator load wrong");

    a_bop_write_one: assert property (
        in_exec && is_bop && instr_reg[SUB_MSB:SUB_LSB] == 4'b0101
        |-> bop.write && bop.word_out[bop.bn] && !skip_now)
        else $error("bit write one wrong");

    a_trap_raise: assert property (
        in_exec && is_mon
        |=> trap_req && trap_level == TRAP_LEVEL
            && trap_param == $past(arg_ext) ##1 !trap_req)
        else $error("monitor trap wrong");

    a_exec_cycle: assert property (
        accept |=> exec_done && !instr_ready ##1 instr_ready)
        else $error("execute sequence wrong");

    c_skip_taken: cover property (in_exec && is_skp && skip_now);
    c_arg_overflow: cover property (in_exec && is_arg && arg_ovf);
    c_bop_skip: cover property (in_exec && is_bop && bop.skip);
    c_trap: cover property (trap_req);
endmodule

/* test/testbench.sv */
// Self-checking bench for the skip, argument and bit-operation unit
`timescale 1ns/1ps
module testbench import exec_pkg::*;;
    logic clk = 0, rst_b = 0, instr_valid = 0, load_en = 0;
    logic [15:0] instr = 0, load_data = 0;
    logic [2:0] load_sel = 0;
    logic instr_ready, exec_done, exec_skip, exec_unhandled, trap_req;
    logic [15:0] reg_d, reg_p, reg_b, reg_l, reg_a, reg_t, reg_x, trap_param;
    logic [7:0] status, sts;
    logic [3:0] trap_level, tl;
    logic [15:0] m [8];
    logic [15:0] dut_r [8];
    logic [15:0] tp;
    int n_errors = 0, check_count = 0;

    // Free-running clock
    always #10 clk = ~clk;

    skip_arg_bitop_exec_unit uut (.clk(clk), .rst_b(rst_b), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready),
        .exec_done(exec_done), .exec_skip(exec_skip),
        .exec_unhandled(exec_unhandled), .load_en(load_en),
        .load_sel(load_sel), .load_data(load_data), .reg_d(reg_d),
        .reg_p(reg_p), .reg_b(reg_b), .reg_l(reg_l), .reg_a(reg_a),
        .reg_t(reg_t), .reg_x(reg_x), .status(status),
        .trap_req(trap_req), .trap_level(trap_level),
        .trap_param(trap_param));

    // Design registers by code
    always_comb begin
        dut_r[0] = 16'h0000;
        dut_r[1] = reg_d;
        dut_r[2] = reg_p;
        dut_r[3] = reg_b;
        dut_r[4] = reg_l;
        dut_r[5] = reg_a;
        dut_r[6] = reg_t;
        dut_r[7] = reg_x;
    end

    // ==========================================================
    // Checking and reference model
    task automatic chk(input string nm, input logic [15:0] e, g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_all();
        for (int i = 1; i < 8; i++)
            chk($sformatf("reg%0d", i), m[i], dut_r[i]);
        chk("status", {8'h00, sts}, {8'h00, status});
        chk("trap_level", {12'h000, tl}, {12'h000, trap_level});
        chk("trap_param", tp, trap_param);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic model(input logic [15:0] w, output logic sk, un);
        logic [15:0] d, s, x, bw;
        logic [16:0] df;
        logic v, k, b, c;
        int r, n;
        x = {{8{w[7]}}, w[7:0]};
        sk = 0;
        un = 0;
        m[2] = m[2] + 16'h1;
        if (w[15:11] == 5'b11000 && w[7:6] == 2'b00) begin
            d = w[2:0] == 0 ? 16'h0 : m[w[2:0]];
            s = w[5:3] == 0 ? 16'h0 : m[w[5:3]];
            df = {1'b0, d} + {1'b0, ~s} + 17'h1;
            v = d[15] != s[15] && df[15] != d[15];
            case (w[9:8])
                0: c = df[15:0] == 0;
                1: c = !df[15];
                2: c = !(df[15] ^ v);
                default: c = df[16];
            endcase
            sk = c ^ w[10];
        end else if (w[15:11] == 5'b11110) begin
            r = w[9:8] == 0 ? 3 : w[9:8] == 1 ? 5 : w[9:8] + 4;
            df = {1'b0, m[r]} + {1'b0, x};
            v = m[r][15] == x[15] && df[15] != x[15];
            if (w[10]) begin
                sts[6] = df[16];
                sts[4] = v;
                sts[5] |= v;
                m[r] = df[15:0];
            end else m[r] = x;
        end else if (w[15:11] == 5'b11111) begin
            r = w[2:0];
            n = w[6:3];
            bw = r == 0 ? {8'h00, sts} : m[r];
            b = bw[n];
            k = sts[2];
            case (w[10:7])
                0: sk = !b;
                1: sk = b;
                2: sk = !b == k;
                3: sk = b == k;
                4, 5: bw[n] = w[7];
                6: bw[n] = !b;
                7: bw[n] = k;
                8, 9: begin
                    bw[n] = k ^ w[7];
                    k = w[7];
                end
                10, 11: k = b ^ w[7];
                12: k = !b & k;
                13: k = !b | k;
                14: k = b & k;
                default: k = b | k;
            endcase
            if (r == 0) sts = bw[7:0];
            else m[r] = bw;
            if (w[10]) sts[2] = k;
        end else if (w[15:8] == 8'hD6) begin
            tl = 4'hE;
            tp = x;
        end else un = 1;
        if (sk) m[2] = m[2] + 16'h1;
    endtask

    // ==========================================================
    // Bus tasks, driven at the falling edge
    task automatic load(input logic [2:0] s, input logic [15:0] d);
        load_sel <= s;
        load_data <= d;
        load_en <= 1'b1;
        @(negedge clk);
        if (s == 0) sts = d[7:0];
        else m[s] = d;
    endtask

    task automatic run(input logic [15:0] w);
        logic sk, un;
        model(w, sk, un);
        load_en <= 1'b0;
        instr <= w;
        instr_valid <= 1'b1;
        @(negedge clk);
        instr_valid <= 1'b0;
        chk("instr_ready", 16'h0, {15'h0, instr_ready});
        chk("exec_done", 16'h1, {15'h0, exec_done});
        chk("exec_skip", {15'h0, sk}, {15'h0, exec_skip});
        chk("exec_unhandled", {15'h0, un}, {15'h0, exec_unhandled});
        @(negedge clk);
        chk("trap_req", {15'h0, w[15:8] == 8'hD6}, {15'h0, trap_req});
        cmp_all();
    endtask

    // Watchdog
    initial begin
        #(20 * 20000);
        n_errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        logic [15:0] vals [6];
        logic [7:0] ims [5];
        logic [15:0] w;
        vals = '{16'h1234, 16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h0001};
        ims = '{8'h7F, 8'h80, 8'h01, 8'hFF, 8'h00};
        for (int i = 0; i < 8; i++) m[i] = 16'h0;
        sts = 8'h00;
        tl = 4'h0;
        tp = 16'h0;
        void'($urandom(32'h60e624c4));
        repeat (16) @(negedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk("instr_ready", 16'h1, {15'h0, instr_ready});
        cmp_all();
        $display("test reset done");
        foreach (vals[i]) foreach (vals[j]) begin
            load(3'h1, vals[i]);
            load(3'h4, vals[j]);
            for (int c = 0; c < 8; c++)
                run({5'b11000, 3'(c), 8'h21});
        end
        run({5'b11000, 3'b011, 8'h11});
        run({5'b11000, 3'b100, 8'h10});
        run(16'hC041);
        run(16'hC081);
        $display("test skip done");
        for (int f = 0; f < 8; f++)
            foreach (ims[i])
                run({5'b11110, 3'(f), ims[i]});
        load(3'h5, 16'h7FFF);
        run(16'hF501);
        load(3'h7, 16'hFFFF);
        run(16'hF701);
        $display("test argument done");
        for (int s = 0; s < 16; s++) repeat (4) begin
            w = {5'b11111, 4'(s), 4'($urandom), 3'($urandom)};
            if (w[2:0] == 3'h2) w[2:0] = 3'h0;
            run(w);
        end
        $display("test bit_ops done");
        run(16'hD680);
        run(16'hD67F);
        $display("test monitor done");
        for (int i = 0; i < 8; i++) load(3'(i), 16'($urandom));
        repeat (80) begin
            w = 16'($urandom) | 16'hC000;
            if (w[15:11] == 5'b11111 && w[2:0] == 3'h2) w[2:0] = 3'h7;
            run(w);
        end
        $display("test random done");
        end_sim();
    end
endmodule
